// ===== core/power_save_pkg.sv
/*
 Shared constants and types for the power-save clock control block:
 register offsets, field positions, reset values, wake timing, states.
 Assumes a 32-bit APB bus with byte addresses and one word per register.
*/
package power_save_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CLOCK_DIVIDER = 8'h00;
    localparam logic [7:0] OFF_PERIPH_DISABLE_THREE = 8'h04;
    localparam logic [7:0] OFF_PERIPH_DISABLE_FOUR = 8'h08;
    localparam logic [7:0] OFF_POWER_SAVE_CMD = 8'h0C;
    localparam logic [7:0] OFF_POWER_STATUS = 8'h10;

    // Clock divider register fields
    localparam int BIT_RESTORE_ON_INTERRUPT = 15;
    localparam int RATIO_HI = 14;
    localparam int RATIO_LO = 12;
    localparam int BIT_CPU_SLOWDOWN_ENABLE = 11;
    localparam int RATIO_W = 3;
    localparam logic [RATIO_W-1:0] RATIO_RESET = 3'h0;

    // Module disable register fields
    localparam int BIT_COMPARATOR_OFF = 10;
    localparam int BIT_CALENDAR_CLOCK_OFF = 9;
    localparam int BIT_CHARGE_TIMER_OFF = 2;

    // Power-save command and status fields
    localparam int BIT_ENTER_IDLE = 0;
    localparam int BIT_STAT_IDLE = 0;
    localparam int BIT_STAT_DOZE = 1;
    localparam int BIT_STAT_CPU_RUN = 2;

    // Doze divider counter covers the slowest ratio of 1:128
    localparam int DOZE_CNT_W = 7;
    localparam logic [DOZE_CNT_W:0] DOZE_ONE = 8'h01;

    // Wake latency in clock cycles, chosen inside the 2 to 4 window
    localparam int WAKE_MIN_CYCLES = 2;
    localparam int WAKE_MAX_CYCLES = 4;
    localparam logic [1:0] WAKE_LAST = 2'h2;

    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_ENTER,
        ST_IDLE,
        ST_WAKE
    } idle_state_t;

endpackage

// ===== core/power_save_clock_gating.sv
/*
 Power-save clock control: Idle entry and wake, Doze CPU clock division,
 and per-peripheral module-disable clock enables, behind an APB slave.
 Assumes i_irq is the OR of individually enabled pending interrupts and
 that all inputs are synchronous to i_core_clk. Clock enables are meant
 for latch-based gating cells downstream.
*/
`timescale 1ns/100ps

module power_save_clock_gating (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_irq,
    input wire logic i_wdt_timeout,
    input wire logic i_wdt_enable,
    input wire logic i_fail_monitor_enable,
    input wire logic i_comparator_present,
    input wire logic i_calendar_present,
    input wire logic i_charge_timer_present,
    output logic o_cpu_clk_en,
    output logic o_periph_clk_en,
    output logic o_comparator_clk_en,
    output logic o_calendar_clk_en,
    output logic o_charge_timer_clk_en,
    output logic o_wdt_clear,
    output logic o_lowpower_rc_run,
    output logic o_idle,
    output logic o_wake_by_irq
);

    typedef struct packed {
        logic restore_on_interrupt;
        logic [power_save_pkg::RATIO_W-1:0] ratio;
        logic cpu_slowdown_enable;
        logic comparator_off;
        logic calendar_clock_off;
        logic charge_timer_off;
        logic prev_slowdown;
        logic [power_save_pkg::RATIO_W-1:0] prev_ratio;
        logic [power_save_pkg::DOZE_CNT_W-1:0] doze_cnt;
        power_save_pkg::idle_state_t state;
        logic [1:0] wake_cnt;
        logic irq_pending;
        logic wake_irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic cpu_clk_en;
        logic periph_clk_en;
        logic comparator_clk_en;
        logic calendar_clk_en;
        logic charge_timer_clk_en;
        logic wdt_clear;
        logic lowpower_rc_run;
        logic idle;
    } state_t;

    state_t state_q;
    state_t state_d;

    logic setup_phase;
    logic write_access;
    logic addr_ok;
    logic [power_save_pkg::DOZE_CNT_W-1:0] doze_mask;
    logic doze_tick;
    logic doze_active;
    logic enter_idle;
    logic [31:0] read_word;

    localparam int DOZE_W = power_save_pkg::DOZE_CNT_W;

    always_comb
    begin
        state_d = state_q;
        read_word = power_save_pkg::WORD_ZERO;
        addr_ok = 1'b1;
        setup_phase = i_psel & ~i_penable;
        write_access = i_psel & i_penable & state_q.pready & i_pwrite & ~state_q.pslverr;
        enter_idle = 1'b0;

        // Doze divider: power-of-two ratios line up with peripheral edges
        doze_mask = DOZE_W'((power_save_pkg::DOZE_ONE << state_q.ratio) - power_save_pkg::DOZE_ONE);
        doze_tick = (state_q.doze_cnt & doze_mask) == '0;
        doze_active = state_q.cpu_slowdown_enable & (state_q.ratio != power_save_pkg::RATIO_RESET);

        // Register read mux; unlisted bits read zero
        case (i_paddr[7:0])
            power_save_pkg::OFF_CLOCK_DIVIDER:
            begin
                read_word[power_save_pkg::BIT_RESTORE_ON_INTERRUPT] = state_q.restore_on_interrupt;
                read_word[power_save_pkg::RATIO_HI:power_save_pkg::RATIO_LO] = state_q.ratio;
                read_word[power_save_pkg::BIT_CPU_SLOWDOWN_ENABLE] = state_q.cpu_slowdown_enable;
            end
            power_save_pkg::OFF_PERIPH_DISABLE_THREE:
            begin
                read_word[power_save_pkg::BIT_COMPARATOR_OFF] = state_q.comparator_off;
                read_word[power_save_pkg::BIT_CALENDAR_CLOCK_OFF] = state_q.calendar_clock_off;
            end
            power_save_pkg::OFF_PERIPH_DISABLE_FOUR:
            begin
                read_word[power_save_pkg::BIT_CHARGE_TIMER_OFF] = state_q.charge_timer_off;
            end
            power_save_pkg::OFF_POWER_SAVE_CMD:
            begin
                read_word = power_save_pkg::WORD_ZERO;
            end
            power_save_pkg::OFF_POWER_STATUS:
            begin
                read_word[power_save_pkg::BIT_STAT_IDLE] = state_q.idle;
                read_word[power_save_pkg::BIT_STAT_DOZE] = doze_active;
                read_word[power_save_pkg::BIT_STAT_CPU_RUN] = state_q.cpu_clk_en;
            end
            default:
            begin
                addr_ok = 1'b0;
            end
        endcase
        if (i_paddr[31:8] != 24'h00_0000)
        begin
            addr_ok = 1'b0;
        end

        // Zero-wait APB: answer registered during setup, ready in access
        state_d.pready = setup_phase;
        if (setup_phase)
        begin
            state_d.prdata = read_word;
            state_d.pslverr = ~addr_ok;
        end
        else
        begin
            state_d.pslverr = 1'b0;
        end

        // Restart keeps the first CPU tick after a change full width
        state_d.prev_slowdown = state_q.cpu_slowdown_enable;
        state_d.prev_ratio = state_q.ratio;
        if ((state_q.cpu_slowdown_enable & ~state_q.prev_slowdown) ||
            (state_q.ratio != state_q.prev_ratio))
        begin
            state_d.doze_cnt = '0;
        end
        else
        begin
            state_d.doze_cnt = state_q.doze_cnt + DOZE_W'(1);
        end

        // Interrupt ends Doze only when restore is enabled
        if (state_q.restore_on_interrupt & state_q.cpu_slowdown_enable & i_irq)
        begin
            state_d.cpu_slowdown_enable = 1'b0;
        end

        // Register writes; a software write overrides the restore above
        // Upper address bits must be zero too, or the write is refused
        if (write_access & addr_ok)
        begin
            case (i_paddr[7:0])
                power_save_pkg::OFF_CLOCK_DIVIDER:
                begin
                    state_d.restore_on_interrupt = i_pwdata[power_save_pkg::BIT_RESTORE_ON_INTERRUPT];
                    state_d.ratio = i_pwdata[power_save_pkg::RATIO_HI:power_save_pkg::RATIO_LO];
                    state_d.cpu_slowdown_enable = i_pwdata[power_save_pkg::BIT_CPU_SLOWDOWN_ENABLE];
                end
                power_save_pkg::OFF_PERIPH_DISABLE_THREE:
                begin
                    state_d.comparator_off = i_pwdata[power_save_pkg::BIT_COMPARATOR_OFF];
                    state_d.calendar_clock_off = i_pwdata[power_save_pkg::BIT_CALENDAR_CLOCK_OFF];
                end
                power_save_pkg::OFF_PERIPH_DISABLE_FOUR:
                begin
                    state_d.charge_timer_off = i_pwdata[power_save_pkg::BIT_CHARGE_TIMER_OFF];
                end
                power_save_pkg::OFF_POWER_SAVE_CMD:
                begin
                    enter_idle = i_pwdata[power_save_pkg::BIT_ENTER_IDLE];
                end
                default:
                begin
                    enter_idle = 1'b0;
                end
            endcase
        end

        // Idle sequencing
        state_d.wdt_clear = 1'b0;
        case (state_q.state)
            power_save_pkg::ST_RUN:
            begin
                if (enter_idle)
                begin
                    state_d.state = power_save_pkg::ST_ENTER;
                    state_d.wake_irq = 1'b0;
                end
            end
            power_save_pkg::ST_ENTER:
            begin
                state_d.wdt_clear = 1'b1;
                state_d.irq_pending = i_irq;
                state_d.state = power_save_pkg::ST_IDLE;
            end
            power_save_pkg::ST_IDLE:
            begin
                if (i_irq | state_q.irq_pending | i_wdt_timeout)
                begin
                    state_d.state = power_save_pkg::ST_WAKE;
                    state_d.wake_cnt = '0;
                    state_d.wake_irq = i_irq | state_q.irq_pending;
                    state_d.irq_pending = 1'b0;
                end
            end
            power_save_pkg::ST_WAKE:
            begin
                state_d.wake_cnt = state_q.wake_cnt + 2'h1;
                if (state_q.wake_cnt == power_save_pkg::WAKE_LAST)
                begin
                    state_d.state = power_save_pkg::ST_RUN;
                end
            end
            default:
            begin
                state_d.state = power_save_pkg::ST_RUN;
            end
        endcase

        // Registered enables only move after a rising edge, safe for latch gating
        state_d.idle = state_d.state != power_save_pkg::ST_RUN;
        state_d.cpu_clk_en = (state_q.state == power_save_pkg::ST_RUN) &
                             ~enter_idle & (~doze_active | doze_tick);
        state_d.periph_clk_en = 1'b1;
        state_d.comparator_clk_en = i_comparator_present & ~state_q.comparator_off;
        state_d.calendar_clk_en = i_calendar_present & ~state_q.calendar_clock_off;
        state_d.charge_timer_clk_en = i_charge_timer_present & ~state_q.charge_timer_off;
        state_d.lowpower_rc_run = i_wdt_enable | i_fail_monitor_enable;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            state_q <= '0;
            state_q.ratio <= power_save_pkg::RATIO_RESET;
            state_q.prev_ratio <= power_save_pkg::RATIO_RESET;
            state_q.state <= power_save_pkg::ST_RUN;
            state_q.cpu_clk_en <= 1'b1;
            state_q.periph_clk_en <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign o_prdata = state_q.prdata;
    assign o_pready = state_q.pready;
    assign o_pslverr = state_q.pslverr;
    assign o_cpu_clk_en = state_q.cpu_clk_en;
    assign o_periph_clk_en = state_q.periph_clk_en;
    assign o_comparator_clk_en = state_q.comparator_clk_en;
    assign o_calendar_clk_en = state_q.calendar_clk_en;
    assign o_charge_timer_clk_en = state_q.charge_timer_clk_en;
    assign o_wdt_clear = state_q.wdt_clear;
    assign o_lowpower_rc_run = state_q.lowpower_rc_run;
    assign o_idle = state_q.idle;
    assign o_wake_by_irq = state_q.wake_irq;

endmodule // power_save_clock_gating

// ===== verif/gated_clock_sink.sv
/*
 Far-side model: CPU core and peripherals counting gated clock ticks.
 Assumes enables are sampled on the rising core clock edge.
*/
`timescale 1ns/100ps

module gated_clock_sink (
    input wire logic i_core_clk,
    input wire logic i_cpu_clk_en,
    input wire logic i_periph_clk_en,
    output logic [15:0] o_cpu_ticks,
    output logic [15:0] o_periph_ticks
);
    // Free-running counts; only differences matter, so no reset needed
    initial
    begin
        o_cpu_ticks = 16'h0000;
        o_periph_ticks = 16'h0000;
    end
    always @(posedge i_core_clk)
    begin
        o_cpu_ticks <= o_cpu_ticks + 16'(i_cpu_clk_en === 1'b1);
        o_periph_ticks <= o_periph_ticks + 16'(i_periph_clk_en === 1'b1);
    end
endmodule // gated_clock_sink

// ===== verif/power_save_checker.sv
/*
 Concurrent checks on the power-save clock control ports.
 Assumes a bind to the top module and one clock domain.
*/
`timescale 1ns/100ps

module power_save_checker (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_irq,
    input wire logic i_wdt_timeout,
    input wire logic i_wdt_enable,
    input wire logic i_fail_monitor_enable,
    input wire logic o_cpu_clk_en,
    input wire logic o_periph_clk_en,
    input wire logic o_wdt_clear,
    input wire logic o_lowpower_rc_run,
    input wire logic o_idle,
    input wire logic o_wake_by_irq
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);

    // Past entry cycle, so a cause held over entry is judged apart
    sequence s_wake;
        $past(o_idle) && o_idle && (i_irq || i_wdt_timeout);
    endsequence
    sequence s_entry_irq;
        $rose(o_idle) && i_irq;
    endsequence

    AST_IDLE_NO_CPU: assert property (o_idle |-> !o_cpu_clk_en)
        else $error("CPU clock enabled during idle");
    AST_WDT_CLEAR: assert property ($rose(o_idle) |-> ##[0:2] o_wdt_clear)
        else $error("No watchdog clear on idle entry");
    AST_PERIPH_RUN: assert property (o_periph_clk_en)
        else $error("Peripheral clock stopped");
    AST_LOW_POWER_RC_OSC: assert property (##1 o_lowpower_rc_run == ($past(i_wdt_enable) || $past(i_fail_monitor_enable)))
        else $error("RC oscillator run flag wrong");
    AST_WAKE: assert property (s_wake |-> ##[1:6] !o_idle)
        else $error("Idle not left on wake cause");
    AST_WAKE_CPU: assert property (s_wake |-> ##[2:5] o_cpu_clk_en)
        else $error("CPU clock late after wake");
    AST_WAKE_CAUSE: assert property (s_wake |-> ##2 o_wake_by_irq == $past(i_irq, 2))
        else $error("Wake cause flag wrong");
    AST_HELD_IRQ: assert property (s_entry_irq |-> ##[2:8] !o_idle)
        else $error("Interrupt during entry lost");
endmodule // power_save_checker

bind power_save_clock_gating power_save_checker i_checker (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_irq(i_irq), .i_wdt_timeout(i_wdt_timeout),
    .i_wdt_enable(i_wdt_enable), .i_fail_monitor_enable(i_fail_monitor_enable),
    .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en), .o_wdt_clear(o_wdt_clear),
    .o_lowpower_rc_run(o_lowpower_rc_run), .o_idle(o_idle), .o_wake_by_irq(o_wake_by_irq)
);

// ===== verif/power_save_clock_gating_bench.sv
/*
 Self-checking bench for the power-save clock control block.
 Assumes zero-wait APB answers and the sink model counting ticks.
*/
`timescale 1ns/100ps
`define CHK(nm, exp, got) compares++; if ((got) !== (exp)) report(nm, 32'(exp), 32'(got));

module power_save_clock_gating_bench;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
    } row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq = 1'b0, wdt_to = 1'b0;
    logic wdt_en = 1'b0, fmon_en = 1'b0, pready, pslverr, cpu_en, per_en, cmp_en, cal_en;
    logic ctm_en, wdt_clr, rc_run, idle, by_irq, qerr;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, q;
    logic [15:0] cpu_ticks, per_ticks, c0, p0;
    int fail_count = 0, compares = 0, cycles = 0;
    row_t rows [6];

    power_save_clock_gating i_dut (
        .i_core_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_irq(irq), .i_wdt_timeout(wdt_to),
        .i_wdt_enable(wdt_en), .i_fail_monitor_enable(fmon_en), .i_comparator_present(1'b1),
        .i_calendar_present(1'b1), .i_charge_timer_present(1'b0), .o_cpu_clk_en(cpu_en),
        .o_periph_clk_en(per_en), .o_comparator_clk_en(cmp_en), .o_calendar_clk_en(cal_en),
        .o_charge_timer_clk_en(ctm_en), .o_wdt_clear(wdt_clr), .o_lowpower_rc_run(rc_run),
        .o_idle(idle), .o_wake_by_irq(by_irq)
    );
    gated_clock_sink i_sink (
        .i_core_clk(clk), .i_cpu_clk_en(cpu_en), .i_periph_clk_en(per_en),
        .o_cpu_ticks(cpu_ticks), .o_periph_ticks(per_ticks)
    );

    always #25 clk = ~clk;

    // Ceiling well above the roughly 2250 cycles the sequence needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            fail_count++;
            end_sim();
        end
    end

    task report(input string nm, input logic [31:0] exp, input logic [31:0] got);
        $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        fail_count++;
    endtask

    task end_sim;
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Leading edge keeps a release and the next setup out of one time step
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h00_0000, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge clk);
            n++;
        end
        q = prdata;
        qerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Mode 0 wakes by watchdog, 1 by interrupt, 2 by interrupt held over entry
    task sleep_wake(input int mode);
        int n;
        n = 0;
        irq <= (mode == 2);
        apb(1'b1, power_save_pkg::OFF_POWER_SAVE_CMD, 32'h0000_0001);
        if (mode != 2)
        begin
            repeat (4) @(posedge clk);
            `CHK("idle", 1'b1, idle)
            `CHK("cpu_en", 1'b0, cpu_en)
            irq <= (mode == 1);
            wdt_to <= (mode == 0);
        end
        repeat (2) @(posedge clk);
        while (idle !== 1'b0 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        irq <= 1'b0;
        wdt_to <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("idle", 1'b0, idle)
        `CHK("cpu_en", 1'b1, cpu_en)
        `CHK("by_irq", (mode != 0), by_irq)
    endtask

    initial
    begin
        rows[0] = '{power_save_pkg::OFF_PERIPH_DISABLE_THREE, 32'hFFFF_FFFF, 32'h0000_0600};
        rows[1] = '{power_save_pkg::OFF_PERIPH_DISABLE_FOUR, 32'hFFFF_FFFF, 32'h0000_0004};
        rows[2] = '{power_save_pkg::OFF_CLOCK_DIVIDER, 32'h0000_7000, 32'h0000_7000};
        rows[3] = '{8'h14, 32'hFFFF_FFFF, 32'h0000_0000};
        rows[4] = '{power_save_pkg::OFF_PERIPH_DISABLE_THREE, 32'h0000_0000, 32'h0000_0000};
        rows[5] = '{power_save_pkg::OFF_PERIPH_DISABLE_FOUR, 32'h0000_0000, 32'h0000_0000};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].addr, rows[i].wdata);
            apb(1'b0, rows[i].addr, 32'h0000_0000);
            `CHK("rdata", rows[i].rdata, q)
            `CHK("pslverr", (rows[i].addr == 8'h14), qerr)
        end
        apb(1'b1, power_save_pkg::OFF_PERIPH_DISABLE_THREE, 32'h0000_0600);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, power_save_pkg::OFF_PERIPH_DISABLE_THREE, 32'h0000_0000);
        `CHK("periph_disable_three", 32'h0000_0000, q)
        `CHK("cmp_en", 1'b1, cmp_en)
        `CHK("ctm_en", 1'b0, ctm_en)
        apb(1'b0, power_save_pkg::OFF_CLOCK_DIVIDER, 32'h0000_0000);
        `CHK("divider", 32'h0000_0000, q)
        for (int r = 0; r < 8; r++)
        begin
            apb(1'b1, power_save_pkg::OFF_CLOCK_DIVIDER, 32'h0000_0800 | (32'(r) << 12));
            repeat (4) @(posedge clk);
            c0 = cpu_ticks;
            p0 = per_ticks;
            repeat (256) @(posedge clk);
            `CHK("cpu_ticks", 16'(256 >> r), 16'(cpu_ticks - c0))
            `CHK("per_ticks", 16'h0100, 16'(per_ticks - p0))
        end
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, power_save_pkg::OFF_CLOCK_DIVIDER, k ? 32'h0000_2800 : 32'h0000_A800);
            irq <= 1'b1;
            @(posedge clk);
            irq <= 1'b0;
            apb(1'b0, power_save_pkg::OFF_CLOCK_DIVIDER, 32'h0000_0000);
            `CHK("divider", k ? 32'h0000_2800 : 32'h0000_A000, q)
        end
        apb(1'b1, power_save_pkg::OFF_CLOCK_DIVIDER, 32'h0000_0000);
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, power_save_pkg::OFF_PERIPH_DISABLE_THREE, k ? 32'h0000_0200 : 32'h0000_0400);
            @(posedge clk);
            `CHK("cmp_en", k ? 1'b0 : 1'b1, cmp_en)
            @(posedge clk);
            `CHK("cmp_en", k ? 1'b1 : 1'b0, cmp_en)
            `CHK("cal_en", k ? 1'b0 : 1'b1, cal_en)
        end
        for (int k = 0; k < 4; k++)
        begin
            wdt_en <= k[0];
            fmon_en <= k[1];
            repeat (2) @(posedge clk);
            `CHK("rc_run", (k != 0), rc_run)
        end
        sleep_wake(1);
        sleep_wake(0);
        sleep_wake(2);
        end_sim();
    end
endmodule // power_save_clock_gating_bench
